// ==== hdl/cfg_bank_if.sv ====
// Carries register writes into the bank and register contents out.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
interface cfg_bank_if;
  logic                                              wr_en;
  logic [7:0]                                        wr_addr;
  logic [7:0]                                        wr_data;
  logic [synth_cfg_pkg::NUM_REGS-1:0][7:0]           regs;
  modport bank (input wr_en, wr_addr, wr_data, output regs);
  modport user (output wr_en, wr_addr, wr_data, input regs);
endinterface

// ==== hdl/cfg_byte_bank.sv ====
// Storage for the eleven configuration bytes with reset values.
// Assumes writes arrive one per cycle on core_clk.
`timescale 1ns/100ps
module cfg_byte_bank
(
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  // Register traffic
  cfg_bank_if.bank   bus
);
  typedef struct packed {
    logic [synth_cfg_pkg::NUM_REGS-1:0][7:0] regs;
  } bank_s;

  bank_s state_q;
  bank_s state_d;

  // Masked byte write at a decoded index
  always_comb
  begin
    state_d = state_q;
    for (int i = 0; i < synth_cfg_pkg::NUM_REGS; i++)
    begin
      if (bus.wr_en &&
          bus.wr_addr == synth_cfg_pkg::BASE_ADDR + 8'(i))
      begin
        state_d.regs[i] = bus.wr_data & synth_cfg_pkg::WRITE_MASKS[i];
      end
    end
  end

  // Reset loads documented defaults
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q.regs <= synth_cfg_pkg::RESET_VALS;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign bus.regs = state_q.regs;
endmodule

// ==== hdl/synth_cfg_pkg.sv ====
// Constants for the synthesizer configuration register bank.
// Assumes an 8-bit register port on the core_clk domain.
// Overview of operation
// - Tri-state bit 4 set puts the second output in high impedance.
// - Bit 0 set divides the reference by four; clear bypasses it.
// - Integer divider is 12 bits: high nibble register, then low byte.
// - Integer divider low byte resets to 0x32, upper nibble to zero.
// - Numerator is 22 bits over three registers, all reset to zero.
// - Denominator is 22 bits over three registers, all reset to zero.
// - Dither field bits 3:2 reset 3; 0 weak, 3 none, others reserved.
// - Order field bits 1:0 reset 0; 0 integer, 3 third order.
// - Bit 5 set enables the reference doubler; resets to one.
// - Pump code resets 0x8; 0x4 is 1.6 mA, 0x8 is 6.4 mA.
package synth_cfg_pkg;
  localparam int          NUM_REGS   = 11;
  localparam logic [7:0]  BASE_ADDR  = 8'h18;
  localparam logic [7:0]  LAST_ADDR  = 8'h22;
  // Register offsets
  localparam logic [7:0]  REF_DIV_OUTPUT_CTL = 8'h18;
  localparam logic [7:0]  INT_DIV_HIGH       = 8'h19;
  localparam logic [7:0]  INT_DIV_LOW        = 8'h1a;
  localparam logic [7:0]  FRAC_NUM_BYTE2     = 8'h1b;
  localparam logic [7:0]  FRAC_NUM_BYTE1     = 8'h1c;
  localparam logic [7:0]  FRAC_NUM_BYTE0     = 8'h1d;
  localparam logic [7:0]  FRAC_DEN_BYTE2     = 8'h1e;
  localparam logic [7:0]  FRAC_DEN_BYTE1     = 8'h1f;
  localparam logic [7:0]  FRAC_DEN_BYTE0     = 8'h20;
  localparam logic [7:0]  MODULATOR_CTL      = 8'h21;
  localparam logic [7:0]  SYNTH_CTL_A        = 8'h22;
  // Index of each register within the bank
  localparam int IDX_REF_CTL  = 0;
  localparam int IDX_INT_HI   = 1;
  localparam int IDX_INT_LO   = 2;
  localparam int IDX_NUM2     = 3;
  localparam int IDX_NUM1     = 4;
  localparam int IDX_NUM0     = 5;
  localparam int IDX_DEN2     = 6;
  localparam int IDX_DEN1     = 7;
  localparam int IDX_DEN0     = 8;
  localparam int IDX_MOD_CTL  = 9;
  localparam int IDX_SYN_CTL  = 10;
  // Reset values, index 10 down to 0
  localparam logic [NUM_REGS-1:0][7:0] RESET_VALS = {
    8'h28, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h32, 8'h00, 8'h10};
  // Writable bits, index 10 down to 0; reserved bits read zero
  localparam logic [NUM_REGS-1:0][7:0] WRITE_MASKS = {
    8'hef, 8'h0f, 8'hff, 8'hff, 8'h3f, 8'hff,
    8'hff, 8'h3f, 8'hff, 8'h0f, 8'h11};
  // Field positions
  localparam int TRISTATE_BIT = 4;
  localparam int REF_DIV_BIT  = 0;
  localparam int DOUBLER_BIT  = 5;
  localparam int DITHER_LSB   = 2;
  localparam int ORDER_LSB    = 0;
  localparam int CP_LSB       = 0;
  localparam int NDIV_W       = 12;
  localparam int FRAC_W       = 22;
  localparam int CP_W         = 4;
  localparam int NDIV_HI_W    = 4;
  localparam int FRAC_HI_W    = 6;
  localparam int MODE_W       = 2;
  localparam logic [7:0] NULL_BYTE = 8'h00;
  // Mode encodings
  typedef enum logic [1:0] {
    DITHER_WEAK = 2'h0,
    DITHER_RSV1 = 2'h1,
    DITHER_RSV2 = 2'h2,
    DITHER_OFF  = 2'h3
  } dither_e;
  typedef enum logic [1:0] {
    ORDER_INTEGER = 2'h0,
    ORDER_RSV1    = 2'h1,
    ORDER_RSV2    = 2'h2,
    ORDER_THIRD   = 2'h3
  } order_e;
  localparam logic [3:0] CP_1P6_MA = 4'h4;
  localparam logic [3:0] CP_6P4_MA = 4'h8;
endpackage

// ==== hdl/synth_cfg_regs.sv ====
// Synthesizer configuration register bank with decoded controls.
// Assumes the serial-port logic presents byte accesses on core_clk.
`timescale 1ns/100ps
module synth_cfg_regs
(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // Register port
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [7:0]                        reg_wdata,
  output logic      [7:0]                        reg_rdata,
  output logic                                   reg_rvalid,
  // Output stage
  output logic                                   second_output_tristate,
  output logic                                   second_clock_output_oe_n,
  // Reference path
  output logic                                   ref_divide_select,
  output logic                                   ref_doubler_en,
  // Feedback divider
  output logic [synth_cfg_pkg::NDIV_W-1:0]       integer_feedback_divider,
  output logic [synth_cfg_pkg::FRAC_W-1:0]       fraction_numerator,
  output logic [synth_cfg_pkg::FRAC_W-1:0]       fraction_denominator,
  // Modulator
  output logic                                   dither_weak_en,
  output logic                                   modulator_third_order,
  output logic                                   mode_code_reserved,
  // Charge pump
  output logic [synth_cfg_pkg::CP_W-1:0]         charge_pump_current_code,
  output logic                                   charge_pump_code_valid
);
  typedef struct packed {
    logic [7:0]                        rdata;
    logic                              rvalid;
    logic                              tristate;
    logic                              oe_n;
    logic                              ref_div;
    logic                              doubler;
    logic [synth_cfg_pkg::NDIV_W-1:0]  ndiv;
    logic [synth_cfg_pkg::FRAC_W-1:0]  num;
    logic [synth_cfg_pkg::FRAC_W-1:0]  den;
    logic                              dither_weak;
    logic                              third_order;
    logic                              mode_rsv;
    logic [synth_cfg_pkg::CP_W-1:0]    cp;
    logic                              cp_valid;
  } ctl_s;

  ctl_s       state_q;
  ctl_s       state_d;
  cfg_bank_if bank_bus ();

  // Byte storage
  cfg_byte_bank u_bank
  (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (bank_bus.bank)
  );

  // Writes go straight to the bank
  assign bank_bus.wr_en   = reg_wr;
  assign bank_bus.wr_addr = reg_addr;
  assign bank_bus.wr_data = reg_wdata;

  // Read mux; unmapped addresses return zero
  function automatic logic [7:0] read_byte
  (
    input logic [7:0]                                   addr,
    input logic [synth_cfg_pkg::NUM_REGS-1:0][7:0]      regs
  );
    if (addr == synth_cfg_pkg::REF_DIV_OUTPUT_CTL)
    begin
      return regs[synth_cfg_pkg::IDX_REF_CTL];
    end
    else if (addr == synth_cfg_pkg::INT_DIV_HIGH)
    begin
      return regs[synth_cfg_pkg::IDX_INT_HI];
    end
    else if (addr == synth_cfg_pkg::INT_DIV_LOW)
    begin
      return regs[synth_cfg_pkg::IDX_INT_LO];
    end
    else if (addr == synth_cfg_pkg::FRAC_NUM_BYTE2)
    begin
      return regs[synth_cfg_pkg::IDX_NUM2];
    end
    else if (addr == synth_cfg_pkg::FRAC_NUM_BYTE1)
    begin
      return regs[synth_cfg_pkg::IDX_NUM1];
    end
    else if (addr == synth_cfg_pkg::FRAC_NUM_BYTE0)
    begin
      return regs[synth_cfg_pkg::IDX_NUM0];
    end
    else if (addr == synth_cfg_pkg::FRAC_DEN_BYTE2)
    begin
      return regs[synth_cfg_pkg::IDX_DEN2];
    end
    else if (addr == synth_cfg_pkg::FRAC_DEN_BYTE1)
    begin
      return regs[synth_cfg_pkg::IDX_DEN1];
    end
    else if (addr == synth_cfg_pkg::FRAC_DEN_BYTE0)
    begin
      return regs[synth_cfg_pkg::IDX_DEN0];
    end
    else if (addr == synth_cfg_pkg::MODULATOR_CTL)
    begin
      return regs[synth_cfg_pkg::IDX_MOD_CTL];
    end
    else if (addr == synth_cfg_pkg::SYNTH_CTL_A)
    begin
      return regs[synth_cfg_pkg::IDX_SYN_CTL];
    end
    else
    begin
      return synth_cfg_pkg::NULL_BYTE;
    end
  endfunction

  // Turns stored bytes into controls; also gives the reset image
  function automatic ctl_s decode_regs
  (
    input logic [synth_cfg_pkg::NUM_REGS-1:0][7:0]      regs
  );
    ctl_s                   c;
    synth_cfg_pkg::dither_e dither;
    synth_cfg_pkg::order_e  order;
    c      = '0;
    dither = synth_cfg_pkg::dither_e'(
      regs[synth_cfg_pkg::IDX_MOD_CTL]
          [synth_cfg_pkg::DITHER_LSB +: synth_cfg_pkg::MODE_W]);
    order  = synth_cfg_pkg::order_e'(
      regs[synth_cfg_pkg::IDX_MOD_CTL]
          [synth_cfg_pkg::ORDER_LSB +: synth_cfg_pkg::MODE_W]);
    c.tristate = regs[synth_cfg_pkg::IDX_REF_CTL]
                     [synth_cfg_pkg::TRISTATE_BIT];
    // Enable is low only while the pin is driven
    c.oe_n     = c.tristate;
    c.ref_div  = regs[synth_cfg_pkg::IDX_REF_CTL]
                     [synth_cfg_pkg::REF_DIV_BIT];
    c.doubler  = regs[synth_cfg_pkg::IDX_SYN_CTL]
                     [synth_cfg_pkg::DOUBLER_BIT];
    c.ndiv = {regs[synth_cfg_pkg::IDX_INT_HI]
                  [synth_cfg_pkg::NDIV_HI_W-1:0],
              regs[synth_cfg_pkg::IDX_INT_LO]};
    // numerator assembly; bytes are live, no shadow
    c.num  = {regs[synth_cfg_pkg::IDX_NUM2]
                  [synth_cfg_pkg::FRAC_HI_W-1:0],
              regs[synth_cfg_pkg::IDX_NUM1],
              regs[synth_cfg_pkg::IDX_NUM0]};
    c.den  = {regs[synth_cfg_pkg::IDX_DEN2]
                  [synth_cfg_pkg::FRAC_HI_W-1:0],
              regs[synth_cfg_pkg::IDX_DEN1],
              regs[synth_cfg_pkg::IDX_DEN0]};
    c.dither_weak = (dither == synth_cfg_pkg::DITHER_WEAK);
    // order decode; code zero is integer-only
    c.third_order = (order == synth_cfg_pkg::ORDER_THIRD);
    // Reserved codes are kept but flagged
    c.mode_rsv    = (dither == synth_cfg_pkg::DITHER_RSV1) ||
                    (dither == synth_cfg_pkg::DITHER_RSV2) ||
                    (order == synth_cfg_pkg::ORDER_RSV1) ||
                    (order == synth_cfg_pkg::ORDER_RSV2);
    // pump current code and its support flag
    c.cp       = regs[synth_cfg_pkg::IDX_SYN_CTL]
                     [synth_cfg_pkg::CP_LSB +: synth_cfg_pkg::CP_W];
    c.cp_valid = (c.cp == synth_cfg_pkg::CP_1P6_MA) ||
                 (c.cp == synth_cfg_pkg::CP_6P4_MA);
    return c;
  endfunction

  // Live decode plus the read port
  always_comb
  begin
    state_d        = decode_regs(bank_bus.regs);
    state_d.rdata  = state_q.rdata;
    state_d.rvalid = reg_rd;
    // Read data holds until the next read
    if (reg_rd)
    begin
      state_d.rdata = read_byte(reg_addr, bank_bus.regs);
    end
  end

  // Control flops; reset mirrors the bank defaults
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // Same image the bank loads, so outputs agree at once
      state_q <= decode_regs(synth_cfg_pkg::RESET_VALS);
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata                = state_q.rdata;
  assign reg_rvalid               = state_q.rvalid;

  // Control outputs straight from flops
  assign second_output_tristate   = state_q.tristate;
  assign second_clock_output_oe_n = state_q.oe_n;
  assign ref_divide_select        = state_q.ref_div;
  assign ref_doubler_en           = state_q.doubler;
  assign integer_feedback_divider = state_q.ndiv;
  assign fraction_numerator       = state_q.num;
  assign fraction_denominator     = state_q.den;
  assign dither_weak_en           = state_q.dither_weak;
  assign modulator_third_order    = state_q.third_order;
  assign mode_code_reserved       = state_q.mode_rsv;
  assign charge_pump_current_code = state_q.cp;
  assign charge_pump_code_valid   = state_q.cp_valid;
endmodule

// ==== testbench/synth_cfg_regs_monitor.sv ====
// Concurrent checks on the configuration bank's ports.
// Assumes a bind from the bench top file connects every port.
`timescale 1ns/100ps
module synth_cfg_regs_monitor
(
  // Clock and reset
  input wire logic                               core_clk,
  input wire logic                               rst,
  // Register port
  input wire logic [7:0]                         reg_addr,
  input wire logic                               reg_wr,
  input wire logic [7:0]                         reg_wdata,
  // Decoded controls
  input wire logic                               second_output_tristate,
  input wire logic                               second_clock_output_oe_n,
  input wire logic                               ref_divide_select,
  input wire logic                               ref_doubler_en,
  input wire logic [synth_cfg_pkg::NDIV_W-1:0]   integer_feedback_divider,
  input wire logic [synth_cfg_pkg::FRAC_W-1:0]   fraction_numerator,
  input wire logic [synth_cfg_pkg::FRAC_W-1:0]   fraction_denominator,
  input wire logic                               dither_weak_en,
  input wire logic                               modulator_third_order,
  input wire logic [synth_cfg_pkg::CP_W-1:0]     charge_pump_current_code,
  input wire logic                               charge_pump_code_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_TRISTATE: assert property (reg_wr && reg_addr == 8'h18 |-> ##2
    second_output_tristate == $past(reg_wdata[4], 2)
    && second_clock_output_oe_n == second_output_tristate)
    else $error("tristate control does not follow write");
  AST_REF_DIV: assert property (reg_wr && reg_addr == 8'h18 |->
    ##2 ref_divide_select == $past(reg_wdata[0], 2))
    else $error("reference divide select does not follow write");
  AST_NDIV_HI: assert property (reg_wr && reg_addr == 8'h19 |-> ##2
    integer_feedback_divider[11:8] == $past(reg_wdata[3:0], 2))
    else $error("divider high nibble wrong");
  AST_NDIV_LO: assert property (reg_wr && reg_addr == 8'h1a |-> ##2
    integer_feedback_divider[7:0] == $past(reg_wdata, 2))
    else $error("divider low byte wrong");
  AST_NUM_HI: assert property (reg_wr && reg_addr == 8'h1b |-> ##2
    fraction_numerator[21:16] == $past(reg_wdata[5:0], 2))
    else $error("numerator top bits wrong");
  AST_DEN_LO: assert property (reg_wr && reg_addr == 8'h20 |-> ##2
    fraction_denominator[7:0] == $past(reg_wdata, 2))
    else $error("denominator low byte wrong");
  AST_DITHER: assert property (reg_wr && reg_addr == 8'h21 |-> ##2
    dither_weak_en == ($past(reg_wdata[3:2], 2) == 2'h0))
    else $error("dither select decode wrong");
  AST_ORDER: assert property (reg_wr && reg_addr == 8'h21 |-> ##2
    modulator_third_order == ($past(reg_wdata[1:0], 2) == 2'h3))
    else $error("order decode wrong");
  AST_DOUBLER: assert property (reg_wr && reg_addr == 8'h22 |-> ##2
    ref_doubler_en == $past(reg_wdata[5], 2))
    else $error("doubler enable does not follow write");
  AST_PUMP: assert property (reg_wr && reg_addr == 8'h22 |-> ##2
    charge_pump_current_code == $past(reg_wdata[3:0], 2)
    && charge_pump_code_valid
       == (charge_pump_current_code inside {4'h4, 4'h8}))
    else $error("pump code or validity wrong");
  AST_RESET: assert property (disable iff (1'b0) rst |=>
    integer_feedback_divider == 12'h032 && fraction_numerator == 22'h000000
    && charge_pump_current_code == 4'h8 && ref_doubler_en)
    else $error("reset values wrong");
endmodule

// ==== testbench/tb_synth_cfg_regs.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the monitor file is compiled before this top.
`timescale 1ns/100ps
module tb_synth_cfg_regs;
  logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lfsr = 8'h61;
  logic        reg_rvalid, tri_o, oe_n, rdiv, dbl, dwk, ord3, mres, cpv;
  logic [11:0] ndiv;
  logic [21:0] num, den;
  logic [3:0]  cp;
  logic [7:0]  ra;
  int          err_total = 0, n_checks = 0;
  logic [7:0]  mdl [11];
  logic [7:0]  rst_v [11] = '{8'h10, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00, 8'h0c, 8'h28};
  logic [7:0]  msk [11] = '{8'h11, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff,
                            8'h3f, 8'hff, 8'hff, 8'h0f, 8'hef};
  synth_cfg_regs i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .second_output_tristate(tri_o), .second_clock_output_oe_n(oe_n),
    .ref_divide_select(rdiv), .ref_doubler_en(dbl),
    .integer_feedback_divider(ndiv), .fraction_numerator(num),
    .fraction_denominator(den), .dither_weak_en(dwk),
    .modulator_third_order(ord3), .mode_code_reserved(mres),
    .charge_pump_current_code(cp), .charge_pump_code_valid(cpv));
  // Clock generation
  always #10 core_clk = ~core_clk;
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] rexp(input logic [7:0] a);
    return (a >= 8'h18 && a <= 8'h22) ? mdl[a - 8'h18] : 8'h00;
  endfunction
  // Host-legal data: reserved bits zero, only supported codes
  function automatic logic [7:0] legal(input logic [7:0] a,
                                       input logic [7:0] d);
    if (a == 8'h21)
      return {4'h0, {2{d[3]}}, {2{d[1]}}};
    if (a == 8'h22)
      return {2'h0, d[5], 1'b0, (d[0] ? 4'h8 : 4'h4)};
    return (a >= 8'h18 && a < 8'h22) ? d & msk[a - 8'h18] : d;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Write strobe stays high across back-to-back writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #2;
    if (a >= 8'h18 && a <= 8'h22)
      mdl[a - 8'h18] = d & msk[a - 8'h18];
  endtask
  task automatic rd(input logic [7:0] a);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #2;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, rexp(a));
  endtask
  task automatic idle;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge core_clk);
    #2;
    check(reg_rvalid, 1'b0);
  endtask
  task automatic chk_all;
    check(tri_o, mdl[0][4]);
    check(oe_n, mdl[0][4]);
    check(rdiv, mdl[0][0]);
    check(ndiv, {mdl[1][3:0], mdl[2]});
    check(num, {mdl[3][5:0], mdl[4], mdl[5]});
    check(den, {mdl[6][5:0], mdl[7], mdl[8]});
    check(dwk, mdl[9][3:2] == 2'h0);
    check(ord3, mdl[9][1:0] == 2'h3);
    check(mres, ^mdl[9][3:2] || ^mdl[9][1:0]);
    check(dbl, mdl[10][5]);
    check(cp, mdl[10][3:0]);
    check(cpv, mdl[10][3:0] == 4'h4 || mdl[10][3:0] == 4'h8);
    for (int a = 8'h17; a < 8'h24; a++)
      rd(a[7:0]);
    idle;
  endtask
  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    summarize;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    #2;
    rst = 1'b0;
    foreach (mdl[i]) mdl[i] = rst_v[i];
    chk_all;
    // All ones, including unmapped places, to probe reserved bits
    for (int a = 8'h17; a < 8'h24; a++)
      wr(a[7:0], 8'hff);
    idle;
    chk_all;
    // Random back-to-back traffic
    for (int i = 0; i < 60; i++)
    begin
      lfsr = step(lfsr);
      ra = 8'h17 + (lfsr % 8'h0d);
      wr(ra, legal(ra, step(lfsr)));
    end
    idle;
    chk_all;
    // Every mode and pump code
    for (int c = 0; c < 16; c++)
    begin
      lfsr = step(lfsr);
      wr(8'h21, c[7:0]);
      wr(8'h22, {lfsr[7:4], c[3:0]});
      idle;
      chk_all;
    end
    wr(8'h1b, 8'h2a);
    wr(8'h1c, 8'h5c);
    wr(8'h1d, 8'ha3);
    wr(8'h1a, 8'h01);
    idle;
    chk_all;
    // Reset in mid-run restores defaults
    rst = 1'b1;
    @(posedge core_clk);
    #2;
    rst = 1'b0;
    foreach (mdl[i]) mdl[i] = rst_v[i];
    chk_all;
    summarize;
  end
endmodule
bind synth_cfg_regs synth_cfg_regs_monitor i_mon (.core_clk(core_clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .second_output_tristate(second_output_tristate),
  .second_clock_output_oe_n(second_clock_output_oe_n),
  .ref_divide_select(ref_divide_select), .ref_doubler_en(ref_doubler_en),
  .integer_feedback_divider(integer_feedback_divider),
  .fraction_numerator(fraction_numerator),
  .fraction_denominator(fraction_denominator),
  .dither_weak_en(dither_weak_en),
  .modulator_third_order(modulator_third_order),
  .charge_pump_current_code(charge_pump_current_code),
  .charge_pump_code_valid(charge_pump_code_valid));
